// [verilog/fimcs_top.sv]
// The AXI4-Lite register port was decided locally.
`timescale 1ns/10ps
`default_nettype none
module fimcs_top (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic [fimcs_pkg::ADDR_W-1:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [fimcs_pkg::DATA_W-1:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [fimcs_pkg::ADDR_W-1:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [fimcs_pkg::DATA_W-1:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  input wire logic soft_rst_i,
  input wire logic xcvr_evt_i,
  input wire logic timer_pend_i,
  input wire logic tx_pend_i,
  input wire logic rx_irq_set_i,
  input wire logic frame_cnt_rd_i,
  input wire logic rx_spec_reset_i,
  input wire fimcs_pkg::fimcs_rx_cond_t rx_cond_i,
  input wire logic rx_data_avail_i,
  input wire logic tx_empty_i,
  input wire fimcs_pkg::fimcs_tx_cond_t tx_cond_i,
  input wire logic ctl_tx_data_i,
  input wire logic ext_rx_data_i,
  input wire logic modem_tx_data_i,
  input wire logic modem_ext_rx_i,
  input wire logic [7:0] dma_wdata_i,
  input wire logic dma_wr_i,
  output logic irq_o,
  output logic tx_en_o,
  output logic rx_en_o,
  output logic [4:0] bank_o,
  output logic [1:0] dma_sel_o,
  output logic ctl_tx_line_o,
  output logic ctl_rx_data_o,
  output logic modem_rx_data_o,
  output logic [7:0] dma_data_o,
  output logic dma_data_vld_o
);
  import fimcs_pkg::*;

  // ----------------------------------------
  // register bus slave
  // ----------------------------------------
  fimcs_mctl_t mctl_reg;
  fimcs_mctl_t mctl_next;
  fimcs_misc_t misc_reg;
  fimcs_misc_t misc_next;
  logic aw_full_reg;
  logic w_full_reg;
  logic [ADDR_W-1:0] awaddr_reg;
  logic [DATA_W-1:0] wdata_reg;
  logic wlane_reg;
  logic awready_reg;
  logic wready_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  logic arready_reg;
  logic rvalid_reg;
  logic [DATA_W-1:0] rdata_reg;
  logic [1:0] rresp_reg;

  wire logic aw_hs = s_axi_awvalid_i && awready_reg;
  wire logic w_hs = s_axi_wvalid_i && wready_reg;
  wire logic ar_hs = s_axi_arvalid_i && arready_reg;
  // address and data may arrive in either order; the write acts once both are held
  wire logic do_wr = aw_full_reg && w_full_reg && !bvalid_reg;
  wire fimcs_sel_t wsel = fimcs_decode(awaddr_reg, mctl_reg.bank);
  wire fimcs_sel_t rsel = fimcs_decode(s_axi_araddr_i, mctl_reg.bank);
  wire logic wr_mctl = do_wr && wsel == SEL_MCTL && wlane_reg;
  wire logic wr_misc = do_wr && wsel == SEL_IDX1 && wlane_reg;
  wire logic rd_stat = ar_hs && rsel == SEL_IDX1;
  wire logic aw_full_next = (aw_full_reg || aw_hs) && !do_wr;
  wire logic w_full_next = (w_full_reg || w_hs) && !do_wr;
  wire logic bvalid_next = do_wr || (bvalid_reg && !s_axi_bready_i);
  wire logic rvalid_next = ar_hs || (rvalid_reg && !s_axi_rready_i);
  wire logic [ADDR_W-1:0] awaddr_next = aw_hs ? s_axi_awaddr_i : awaddr_reg;
  wire logic [DATA_W-1:0] wdata_next = w_hs ? s_axi_wdata_i : wdata_reg;
  wire logic wlane_next = w_hs ? s_axi_wstrb_i[0] : wlane_reg;
  wire logic [1:0] bresp_next = do_wr ? ((wsel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY) : bresp_reg;

  // ----------------------------------------
  // control and status
  // ----------------------------------------
  logic xcvr_reg;
  logic rx_pend_reg;
  // software must keep the bank within 0..3; the field stores what it is given
  assign mctl_next = soft_rst_i ? fimcs_mctl_t'(MCTL_RST) :
                     wr_mctl ? fimcs_mctl_t'(wdata_reg[7:0]) : mctl_reg;
  assign misc_next = soft_rst_i ? fimcs_misc_t'(MISC_RST) :
                     wr_misc ? fimcs_misc_t'(wdata_reg[7:0] & MISC_WMASK) : misc_reg;
  wire logic rx_off = wr_mctl && mctl_reg.rx_en && !wdata_reg[MC_RXEN];
  wire logic rx_clr = frame_cnt_rd_i || rx_spec_reset_i || rx_off || soft_rst_i;
  // an event in the clearing cycle wins, so none is lost
  wire logic rx_pend_next = rx_irq_set_i || (rx_pend_reg && !rx_clr);
  wire logic xcvr_next = xcvr_evt_i || (xcvr_reg && !(rd_stat || soft_rst_i));
  wire logic [2:0] stat_code = fimcs_code(rx_cond_i, rx_data_avail_i, tx_empty_i, tx_cond_i);
  wire logic [7:0] stat_byte = {xcvr_reg, timer_pend_i, tx_pend_i, rx_pend_reg,
                                stat_code, 1'b0};
  wire logic [DATA_W-1:0] rd_word = (rsel == SEL_MCTL) ? fimcs_pad(mctl_reg) :
                                    (rsel == SEL_IDX1) ? fimcs_pad(stat_byte) : '0;
  wire logic [DATA_W-1:0] rdata_next = ar_hs ? rd_word : rdata_reg;
  wire logic [1:0] rresp_next = ar_hs ? ((rsel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY) : rresp_reg;
  wire logic pend_any = xcvr_reg || timer_pend_i || tx_pend_i || rx_pend_reg;
  wire logic irq_next = mctl_reg.gate && pend_any;

  // ----------------------------------------
  // data paths
  // ----------------------------------------
  // idle line is high; a disabled side sees only idle
  wire logic tx_line_next = mctl_reg.tx_en ? ctl_tx_data_i : 1'b1;
  wire logic ctl_rx_mux = misc_reg.cloop ? ctl_tx_data_i : ext_rx_data_i;
  wire logic ctl_rx_next = mctl_reg.rx_en ? ctl_rx_mux : 1'b1;
  wire logic modem_rx_next = misc_reg.mloop ? modem_tx_data_i : modem_ext_rx_i;
  logic irq_reg;
  logic tx_line_reg;
  logic ctl_rx_reg;
  logic modem_rx_reg;
  logic [7:0] dma_data;
  logic dma_vld;

  fimcs_hold u_hold (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .zhold_i(misc_reg.zhold),
    .wdata_i(dma_wdata_i),
    .wr_i(dma_wr_i),
    .data_o(dma_data),
    .vld_o(dma_vld)
  );

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      aw_full_reg <= 1'b0;
      w_full_reg <= 1'b0;
      awaddr_reg <= '0;
      wdata_reg <= '0;
      wlane_reg <= 1'b0;
      awready_reg <= 1'b0;
      wready_reg <= 1'b0;
      bvalid_reg <= 1'b0;
      bresp_reg <= RESP_OKAY;
      arready_reg <= 1'b0;
      rvalid_reg <= 1'b0;
      rdata_reg <= '0;
      rresp_reg <= RESP_OKAY;
    end else begin
      aw_full_reg <= aw_full_next;
      w_full_reg <= w_full_next;
      awaddr_reg <= awaddr_next;
      wdata_reg <= wdata_next;
      wlane_reg <= wlane_next;
      awready_reg <= !aw_full_next && !bvalid_next;
      wready_reg <= !w_full_next && !bvalid_next;
      bvalid_reg <= bvalid_next;
      bresp_reg <= bresp_next;
      arready_reg <= !rvalid_next;
      rvalid_reg <= rvalid_next;
      rdata_reg <= rdata_next;
      rresp_reg <= rresp_next;
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      mctl_reg <= fimcs_mctl_t'(MCTL_RST);
      misc_reg <= fimcs_misc_t'(MISC_RST);
      xcvr_reg <= 1'b0;
      rx_pend_reg <= 1'b0;
      irq_reg <= 1'b0;
      tx_line_reg <= 1'b1;
      ctl_rx_reg <= 1'b1;
      modem_rx_reg <= 1'b1;
    end else begin
      mctl_reg <= mctl_next;
      misc_reg <= misc_next;
      xcvr_reg <= xcvr_next;
      rx_pend_reg <= rx_pend_next;
      irq_reg <= irq_next;
      tx_line_reg <= tx_line_next;
      ctl_rx_reg <= ctl_rx_next;
      modem_rx_reg <= modem_rx_next;
    end
  end

  assign s_axi_awready_o = awready_reg;
  assign s_axi_wready_o = wready_reg;
  assign s_axi_bvalid_o = bvalid_reg;
  assign s_axi_bresp_o = bresp_reg;
  assign s_axi_arready_o = arready_reg;
  assign s_axi_rvalid_o = rvalid_reg;
  assign s_axi_rdata_o = rdata_reg;
  assign s_axi_rresp_o = rresp_reg;
  assign irq_o = irq_reg;
  assign tx_en_o = mctl_reg.tx_en;
  assign rx_en_o = mctl_reg.rx_en;
  assign bank_o = mctl_reg.bank;
  assign dma_sel_o = misc_reg.dma_sel;
  assign ctl_tx_line_o = tx_line_reg;
  assign ctl_rx_data_o = ctl_rx_reg;
  assign modem_rx_data_o = modem_rx_reg;
  assign dma_data_o = dma_data;
  assign dma_data_vld_o = dma_vld;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);

  sequence s_wr_mctl;
    wr_mctl && !soft_rst_i;
  endsequence
  sequence s_zhold_wr;
    misc_reg.zhold && dma_wr_i && !wr_misc && !soft_rst_i;
  endsequence
  sequence s_quiet5;
    (!dma_wr_i && misc_reg.zhold)[*5];
  endsequence

  a_gate_blocks_irq: assert property (!mctl_reg.gate |=> !irq_o)
    else $error("interrupt raised with gate closed");
  a_gate_passes_irq: assert property (mctl_reg.gate && (rx_pend_reg || timer_pend_i)
                                      |=> irq_o)
    else $error("pending interrupt not signalled");
  a_tx_idle_off: assert property (!tx_en_o |=> ctl_tx_line_o)
    else $error("transmit line active while disabled");
  a_rx_idle_off: assert property (!rx_en_o |=> ctl_rx_data_o)
    else $error("receive data passed while disabled");
  a_mctl_write: assert property (s_wr_mctl |=> mctl_reg == $past(wdata_reg[7:0]))
    else $error("master control write lost");
  a_mctl_any_bank: assert property (awaddr_reg[ADDR_W-1:IDX_LSB] == IDX_MCTL |-> wsel == SEL_MCTL)
    else $error("master control not decoded in this bank");
  a_xcvr_sticky: assert property (xcvr_evt_i |=> xcvr_reg)
    else $error("transceiver event not recorded");
  a_timer_shown: assert property (rd_stat |=> s_axi_rdata_o[MS_TIMER] == $past(timer_pend_i))
    else $error("timer pending not shown");
  a_tx_shown: assert property (rd_stat |=> s_axi_rdata_o[MS_TX] == $past(tx_pend_i))
    else $error("transmit pending not shown");
  a_rx_clears: assert property (rx_clr && !rx_irq_set_i |=> !rx_pend_reg && !s_axi_rdata_o[MS_RX]
                                || !rx_pend_reg)
    else $error("receive pending not cleared");
  a_code_prio: assert property ((|rx_cond_i) |-> stat_code == CODE_RX_SPEC)
    else $error("receive special code lost priority");
  a_stat_rsvd: assert property (rd_stat |=> !s_axi_rdata_o[MS_RSVD])
    else $error("status reserved bit set");
  a_misc_write: assert property (wr_misc && !soft_rst_i |=>
                                 misc_reg == $past(wdata_reg[7:0] & MISC_WMASK))
    else $error("misc control write wrong");
  a_ctl_loop: assert property (misc_reg.cloop && mctl_reg.rx_en |=>
                               ctl_rx_data_o == $past(ctl_tx_data_i))
    else $error("controller loopback broken");
  a_modem_loop: assert property (misc_reg.mloop |=> modem_rx_data_o == $past(modem_tx_data_i))
    else $error("modem loopback broken");
  a_hold_extend: assert property (s_zhold_wr ##1 s_quiet5 |=>
                                  dma_data_vld_o && dma_data_o == $past(dma_wdata_i, 6))
    else $error("zero hold data not delivered");
  a_soft_clear: assert property (soft_rst_i |=> mctl_reg == MCTL_RST)
    else $error("master control not cleared");

  // ----------------------------------------
  // bus, status, misc control and dma checks
  // ----------------------------------------
  a_bvalid_hold: assert property (s_axi_bvalid_o && !s_axi_bready_i |=>
                                  s_axi_bvalid_o && $stable(s_axi_bresp_o))
    else $error("write response dropped early");
  a_rvalid_hold: assert property (s_axi_rvalid_o && !s_axi_rready_i |=>
                                  s_axi_rvalid_o && $stable(s_axi_rdata_o))
    else $error("read data dropped early");
  a_one_write: assert property (s_axi_bvalid_o |-> !s_axi_awready_o && !s_axi_wready_o)
    else $error("write accepted while response pending");
  a_one_read: assert property (s_axi_rvalid_o |-> !s_axi_arready_o)
    else $error("read accepted while data pending");
  a_rx_off_clear: assert property (rx_off && !rx_irq_set_i |=> !rx_pend_reg)
    else $error("receive pending kept after disable");
  a_rx_shown: assert property (rd_stat |=> s_axi_rdata_o[MS_RX] == $past(rx_pend_reg))
    else $error("receive pending not shown");
  a_xcvr_rd_clear: assert property (rd_stat && !xcvr_evt_i |=> !xcvr_reg)
    else $error("transceiver bit not cleared by read");
  a_code_data: assert property (!(|rx_cond_i) && rx_data_avail_i |->
                                stat_code == CODE_RX_DATA)
    else $error("receive data code wrong");
  a_code_empty: assert property (!(|rx_cond_i) && !rx_data_avail_i && tx_empty_i |->
                                 stat_code == CODE_TX_EMPTY)
    else $error("transmit empty code wrong");
  a_code_tx_spec: assert property (!(|rx_cond_i) && !rx_data_avail_i && !tx_empty_i &&
                                   (|tx_cond_i) |-> stat_code == CODE_TX_SPEC)
    else $error("transmit special code wrong");
  a_misc_rsvd: assert property (misc_reg.rsvd == '0)
    else $error("misc reserved bits set");
  a_soft_misc: assert property (soft_rst_i |=> misc_reg == MISC_RST)
    else $error("misc control not cleared");
  a_unmapped_wr: assert property (do_wr && wsel == SEL_NONE && !soft_rst_i |=>
                                  $stable(mctl_reg) && $stable(misc_reg))
    else $error("unmapped write changed a register");
  a_hold_bypass: assert property (!misc_reg.zhold && dma_wr_i |=>
                                  dma_data_vld_o && dma_data_o == $past(dma_wdata_i))
    else $error("direct dma data not delivered");
endmodule
`default_nettype wire

// [verilog/fimcs_pkg.sv]
// Operation
// - with the interrupt gate bit 7 of master control at 0 no interrupt leaves the block.
// - with transmitter enable bit 6 at 0 no packet is sent; setting it starts the transmitter.
// - with receiver enable bit 5 at 0 no packet is taken in; setting it starts the receiver.
// - bits 4 to 0 of master control select the bank, and software writes only 0 to 3.
// - master control answers at index 0 whatever bank is selected.
// - status bit 7 is set by a transceiver insertion or removal event.
// - status bit 6 shows a pending timer interrupt.
// - status bit 5 shows a pending transmitter interrupt.
// - status bit 4 shows a pending receive interrupt, cleared by five named events.
// - status bits 3 to 1 carry the prioritised source code 100, 101, 110, 111.
// - receive and transmit special codes gather their listed conditions.
// - bank 0 index 1 reads master status with bit 0 zero and writes misc control.
// - misc control holds dma select 7:6, loopbacks 5 and 4, zero hold 3, bits 2:0 reserved.
// - controller loopback feeds controller transmit data back to its receive input.
// - modem loopback feeds the modem transmit output back to its receive input.
// - zero hold latches dma write data twice and holds it past 40 ns; clears on reset.
package fimcs_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int IDX_LSB = 2;
  localparam int IDX_W = ADDR_W - IDX_LSB;
  // printed offsets are register indices; byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_MCTL = 6'h00;
  localparam logic [IDX_W-1:0] IDX_MSTAT = 6'h01;
  localparam logic [IDX_W-1:0] IDX_MISC = 6'h01;
  localparam logic [4:0] BANK0 = 5'h00;
  localparam logic [4:0] BANK_MAX = 5'h03;
  localparam int MS_XCVR = 7;
  localparam int MS_TIMER = 6;
  localparam int MS_TX = 5;
  localparam int MS_RX = 4;
  localparam int MS_RSVD = 0;
  localparam int MC_RXEN = 5;
  localparam logic [7:0] MCTL_RST = 8'h00;
  localparam logic [7:0] MISC_RST = 8'h00;
  localparam logic [7:0] MISC_WMASK = 8'hF8;
  localparam logic [2:0] CODE_NONE = 3'h0;
  localparam logic [2:0] CODE_RX_SPEC = 3'h4;
  localparam logic [2:0] CODE_RX_DATA = 3'h5;
  localparam logic [2:0] CODE_TX_EMPTY = 3'h6;
  localparam logic [2:0] CODE_TX_SPEC = 3'h7;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam int CLK_MHZ = 100;
  localparam int HOLD_NS = 40;
  // strictly longer than the hold figure, so one cycle on top
  localparam int HOLD_CYC = HOLD_NS * CLK_MHZ / 1000 + 1;
  localparam logic [2:0] HOLD_LOAD = 3'(HOLD_CYC);
  localparam logic [2:0] HOLD_LAST = 3'h1;

  typedef struct packed {
    logic gate;
    logic tx_en;
    logic rx_en;
    logic [4:0] bank;
  } fimcs_mctl_t;

  typedef struct packed {
    logic [1:0] dma_sel;
    logic cloop;
    logic mloop;
    logic zhold;
    logic [2:0] rsvd;
  } fimcs_misc_t;

  typedef struct packed {
    logic overrun;
    logic frame_err;
    logic end_of_frame;
    logic abort;
    logic sync_hunt;
  } fimcs_rx_cond_t;

  typedef struct packed {
    logic underrun;
    logic end_of_message;
    logic early_end_of_message;
  } fimcs_tx_cond_t;

  typedef enum logic [1:0] {
    SEL_NONE = 2'b00,
    SEL_MCTL = 2'b01,
    SEL_IDX1 = 2'b10
  } fimcs_sel_t;

  function automatic fimcs_sel_t fimcs_decode(input logic [ADDR_W-1:0] addr,
                                             input logic [4:0] bank);
    logic [IDX_W-1:0] idx;
    idx = addr[ADDR_W-1:IDX_LSB];
    if (idx == IDX_MCTL) begin
      fimcs_decode = SEL_MCTL;
    end else if (idx == IDX_MSTAT && bank == BANK0) begin
      fimcs_decode = SEL_IDX1;
    end else begin
      fimcs_decode = SEL_NONE;
    end
  endfunction

  function automatic logic [2:0] fimcs_code(input fimcs_rx_cond_t rs, input logic rx_data,
                                            input logic tx_empty, input fimcs_tx_cond_t ts);
    if (|rs) begin
      fimcs_code = CODE_RX_SPEC;
    end else if (rx_data) begin
      fimcs_code = CODE_RX_DATA;
    end else if (tx_empty) begin
      fimcs_code = CODE_TX_EMPTY;
    end else if (|ts) begin
      fimcs_code = CODE_TX_SPEC;
    end else begin
      fimcs_code = CODE_NONE;
    end
  endfunction

  function automatic logic [DATA_W-1:0] fimcs_pad(input logic [7:0] b);
    fimcs_pad = {{(DATA_W-8){1'b0}}, b};
  endfunction
endpackage

// [verilog/fimcs_hold.sv]
`timescale 1ns/10ps
`default_nettype none
module fimcs_hold (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic zhold_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  output logic [7:0] data_o,
  output logic vld_o
);
  import fimcs_pkg::*;
  logic [7:0] first_reg;
  logic [7:0] first_next;
  logic [7:0] second_reg;
  logic [7:0] second_next;
  logic [2:0] cnt_reg;
  logic [2:0] cnt_next;
  logic vld_reg;
  logic vld_next;
  wire logic last = (cnt_reg == HOLD_LAST);
  // a new write inside the hold window restarts it; the older byte is lost unless the write falls on the last count, HOLD_LAST
  assign first_next = (wr_i && zhold_i) ? wdata_i : first_reg;
  assign cnt_next = (wr_i && zhold_i) ? HOLD_LOAD : (cnt_reg != 3'h0) ? cnt_reg - 3'h1 : cnt_reg;
  assign second_next = (wr_i && !zhold_i) ? wdata_i : last ? first_reg : second_reg;
  assign vld_next = zhold_i ? last : wr_i;
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      first_reg <= 8'h00;
      second_reg <= 8'h00;
      cnt_reg <= 3'h0;
      vld_reg <= 1'b0;
    end else begin
      first_reg <= first_next;
      second_reg <= second_next;
      cnt_reg <= cnt_next;
      vld_reg <= vld_next;
    end
  end
  assign data_o = second_reg;
  assign vld_o = vld_reg;
endmodule
`default_nettype wire

// [tb/fimcs_host.sv]
`timescale 1ns/10ps
`default_nettype none
module fimcs_host (
  input wire logic clk_i,
  output logic [7:0] awaddr_o,
  output logic awvalid_o,
  input wire logic awready_i,
  output logic [31:0] wdata_o,
  output logic [3:0] wstrb_o,
  output logic wvalid_o,
  input wire logic wready_i,
  input wire logic [1:0] bresp_i,
  input wire logic bvalid_i,
  output logic bready_o,
  output logic [7:0] araddr_o,
  output logic arvalid_o,
  input wire logic arready_i,
  input wire logic [31:0] rdata_i,
  input wire logic [1:0] rresp_i,
  input wire logic rvalid_i,
  output logic rready_o
);
  // ----------------------------------------
  // bus master, one write and one read at a time
  // ----------------------------------------
  initial begin
    {awaddr_o, awvalid_o, wdata_o, wvalid_o, bready_o} = '0;
    {araddr_o, arvalid_o, rready_o} = '0;
    wstrb_o = 4'hF;
  end

  // both channels offered together, each dropped only at its own handshake edge
  task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] r);
    @(posedge clk_i);
    awaddr_o <= a;
    wdata_o <= v;
    awvalid_o <= 1'b1;
    wvalid_o <= 1'b1;
    bready_o <= 1'b1;
    do begin
      @(posedge clk_i);
      if (awvalid_o && awready_i) awvalid_o <= 1'b0;
      if (wvalid_o && wready_i) wvalid_o <= 1'b0;
    end while (!bvalid_i);
    r = bresp_i;
    bready_o <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] r);
    @(posedge clk_i);
    araddr_o <= a;
    arvalid_o <= 1'b1;
    rready_o <= 1'b1;
    do begin
      @(posedge clk_i);
      if (arvalid_o && arready_i) arvalid_o <= 1'b0;
    end while (!rvalid_i);
    v = rdata_i;
    r = rresp_i;
    rready_o <= 1'b0;
  endtask
endmodule
`default_nettype wire

// [tb/fimcs_tb_top.sv]
`timescale 1ns/10ps
`default_nettype none
module fimcs_tb_top;
  import fimcs_pkg::*;
  logic clk, nrst, timer_pend, tx_pend, rx_avail, tx_empty;
  logic [5:0] pls;
  logic [3:0] ser;
  logic [7:0] dma_wdata, st;
  fimcs_rx_cond_t rx_cond;
  fimcs_tx_cond_t tx_cond;
  logic [7:0] awaddr, araddr, ddata;
  logic [31:0] wdata, rdata, d;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, r, dma_sel;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic irq, tx_en, rx_en, ctl_tx_line, ctl_rx, modem_rx, dvld;
  logic [4:0] bank;
  logic [9:0] pv [4] = '{10'h3FF, 10'h01F, 10'h00F, 10'h000};
  logic [2:0] pc [4] = '{CODE_RX_SPEC, CODE_RX_DATA, CODE_TX_EMPTY, CODE_NONE};
  int errors, checked, cycles, n0, n1;

  fimcs_host u_fimcs_host (.clk_i(clk), .awaddr_o(awaddr), .awvalid_o(awvalid),
    .awready_i(awready), .wdata_o(wdata), .wstrb_o(wstrb), .wvalid_o(wvalid),
    .wready_i(wready), .bresp_i(bresp), .bvalid_i(bvalid), .bready_o(bready),
    .araddr_o(araddr), .arvalid_o(arvalid), .arready_i(arready), .rdata_i(rdata),
    .rresp_i(rresp), .rvalid_i(rvalid), .rready_o(rready));

  fimcs_top u_fimcs_top (.clk_i(clk), .nrst_i(nrst), .s_axi_awaddr_i(awaddr),
    .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
    .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready),
    .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
    .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
    .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
    .s_axi_rready_i(rready), .soft_rst_i(pls[4]), .xcvr_evt_i(pls[0]),
    .timer_pend_i(timer_pend), .tx_pend_i(tx_pend), .rx_irq_set_i(pls[1]),
    .frame_cnt_rd_i(pls[2]), .rx_spec_reset_i(pls[3]), .rx_cond_i(rx_cond),
    .rx_data_avail_i(rx_avail), .tx_empty_i(tx_empty), .tx_cond_i(tx_cond),
    .ctl_tx_data_i(ser[3]), .ext_rx_data_i(ser[2]), .modem_tx_data_i(ser[1]),
    .modem_ext_rx_i(ser[0]), .dma_wdata_i(dma_wdata), .dma_wr_i(pls[5]), .irq_o(irq),
    .tx_en_o(tx_en), .rx_en_o(rx_en), .bank_o(bank), .dma_sel_o(dma_sel),
    .ctl_tx_line_o(ctl_tx_line), .ctl_rx_data_o(ctl_rx), .modem_rx_data_o(modem_rx),
    .dma_data_o(ddata), .dma_data_vld_o(dvld));

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  always #5 clk = ~clk;

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic close_out();
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic pulse(input int b);
    @(posedge clk);
    pls[b] <= 1'b1;
    @(posedge clk);
    pls <= '0;
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [7:0] e, input logic [1:0] er);
    u_fimcs_host.rd(a, d, r);
    chk(d, {24'h0, e});
    chk(r, er);
  endtask

  task automatic wrchk(input logic [7:0] a, input logic [7:0] v, input logic [1:0] er);
    u_fimcs_host.wr(a, {24'h0, v}, r);
    chk(r, er);
  endtask

  task automatic stat();
    u_fimcs_host.rd(8'h04, d, r);
    st = d[7:0];
  endtask

  // counts edges from the write strobe to the valid pulse; timeout guards a lost pulse
  task automatic dma(input logic [7:0] b, output int n);
    @(posedge clk);
    dma_wdata <= b;
    pls[5] <= 1'b1;
    @(posedge clk);
    pls[5] <= 1'b0;
    n = 1;
    while (!dvld) begin
      @(posedge clk);
      n++;
    end
    chk(ddata, b);
  endtask

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      errors++;
      close_out();
    end
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    {clk, nrst, timer_pend, tx_pend, rx_avail, tx_empty} = '0;
    {pls, ser, dma_wdata, rx_cond, tx_cond} = '0;
    {errors, checked} = '0;
    step(16);
    nrst <= 1'b1;
    rdchk(8'h00, 8'h00, RESP_OKAY);
    chk({tx_en, rx_en, bank, irq}, 8'h00);
    // banks written stay within 0 to 3
    wrchk(8'h00, 8'hE2, RESP_OKAY);
    rdchk(8'h00, 8'hE2, RESP_OKAY);
    rdchk(8'h04, 8'h00, RESP_SLVERR);
    wrchk(8'h04, 8'hFF, RESP_SLVERR);
    step(2);
    chk({tx_en, rx_en, bank}, {2'b11, 5'h02});
    wrchk(8'h00, 8'h03, RESP_OKAY);
    rdchk(8'h00, 8'h03, RESP_OKAY);
    wrchk(8'h00, 8'h60, RESP_OKAY);
    for (int j = 0; j < 8; j++) begin
      @(posedge clk);
      {rx_cond, tx_cond} <= 8'h01 << j;
      stat();
      chk(st[3:1], j < 3 ? CODE_TX_SPEC : CODE_RX_SPEC);
    end
    for (int j = 0; j < 4; j++) begin
      @(posedge clk);
      {rx_cond, rx_avail, tx_empty, tx_cond} <= pv[j];
      stat();
      chk(st[3:0], {pc[j], 1'b0});
    end
    timer_pend <= 1'b1;
    stat();
    chk(st[7:4], 4'b0100);
    {timer_pend, tx_pend} <= 2'b01;
    stat();
    chk(st[7:4], 4'b0010);
    tx_pend <= 1'b0;
    pulse(0);
    stat();
    chk(st[7:4], 4'b1000);
    // rx pending: set, then each clearing event in turn
    for (int k = 0; k < 4; k++) begin
      pulse(1);
      stat();
      chk(st[4], 1'b1);
      if (k < 2) pulse(k + 2);
      if (k == 2) wrchk(8'h00, 8'h40, RESP_OKAY);
      if (k == 3) pulse(4);
      stat();
      chk(st[4], 1'b0);
      wrchk(8'h00, 8'h60, RESP_OKAY);
    end
    timer_pend <= 1'b1;
    step(3);
    chk(irq, 1'b0);
    wrchk(8'h00, 8'hE0, RESP_OKAY);
    step(3);
    chk(irq, 1'b1);
    timer_pend <= 1'b0;
    step(3);
    chk(irq, 1'b0);
    wrchk(8'h04, 8'hF0, RESP_OKAY);
    step(2);
    chk(dma_sel, 2'b11);
    for (int v = 0; v < 4; v++) begin
      ser <= {v[0], ~v[0], v[1], ~v[1]};
      step(3);
      chk({ctl_tx_line, ctl_rx, modem_rx}, {v[0], v[0], v[1]});
    end
    wrchk(8'h04, 8'h40, RESP_OKAY);
    ser <= 4'b0101;
    step(3);
    chk({dma_sel, ctl_rx, modem_rx}, 4'b0111);
    wrchk(8'h00, 8'h00, RESP_OKAY);
    ser <= 4'b0000;
    step(3);
    chk({ctl_tx_line, ctl_rx}, 2'b11);
    dma(8'hA5, n0);
    wrchk(8'h04, 8'h48, RESP_OKAY);
    dma(8'h3C, n1);
    chk(n1 - n0, 40 / 10 + 1);
    step(3);
    chk({dvld, ddata}, {1'b0, 8'h3C});
    wrchk(8'h00, 8'hE1, RESP_OKAY);
    pulse(4);
    dma(8'h5A, n1);
    chk(n1, n0);
    rdchk(8'h00, 8'h00, RESP_OKAY);
    // hardware reset in mid-run must drop a pending receive interrupt
    pulse(1);
    nrst <= 1'b0;
    step(2);
    nrst <= 1'b1;
    stat();
    chk(st[4], 1'b0);
    close_out();
  end
endmodule
`default_nettype wire
